// file: dv/acs_sequencer_assertions.sv
// Port checker for the conversion sequencer.
// Assumes a bind onto acs_sequencer from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_assertions
(
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    clk_en,
  input var  acs_pkg::acs_config_type cfg,
  input wire logic                    converter_enable,
  input wire logic                    start_set,
  input wire logic                    start_clear,
  input wire logic                    flag_clear,
  input wire logic                    conv_irq_enable,
  input wire logic                    sleep_req,
  input wire logic                    compare_trigger,
  input wire logic                    start_status,
  input wire logic                    conv_complete_flag,
  input wire logic                    wake_event,
  input wire logic                    timer_reset,
  input wire logic [7:0]              result_high_byte,
  input wire logic [7:0]              result_low_byte
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // =====================================
  // Sequences
  sequence s_take;
    clk_en && converter_enable && !start_status && !sleep_req;
  endsequence
  sequence s_run;
    start_status [*2];
  endsequence
  // =====================================
  // Properties
  property p_start;
    s_take ##0 (start_set && cfg.conv_clock_select == acs_pkg::CS_DIV2) |=> s_run;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_trig;
    s_take ##0 compare_trigger |=> start_status ##[0:1] timer_reset;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");
  property p_off;
    !converter_enable && clk_en |=> !start_status;
  endproperty
  a_off: assert property (p_off) else $error("running while disabled");
  property p_done;
    $fell(start_status) && $past(converter_enable) && !$past(start_clear)
      && !$past(sleep_req) |-> conv_complete_flag;
  endproperty
  a_done: assert property (p_done) else $error("no flag at completion");
  property p_sticky;
    conv_complete_flag && !flag_clear && clk_en |=> conv_complete_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_right;
    $rose(conv_complete_flag) && cfg.result_justify |=> result_high_byte[7:2] == 6'h00;
  endproperty
  a_right: assert property (p_right) else $error("high byte not zero filled");
  property p_left;
    $rose(conv_complete_flag) && !cfg.result_justify |=> result_low_byte[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) else $error("low byte not zero filled");
  property p_wake;
    wake_event |-> $past(conv_irq_enable) && $past(sleep_req);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_pulse;
    wake_event && clk_en |=> !wake_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake held too long");
endmodule
`default_nettype wire

// file: dv/acs_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb_top;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  logic                    start_set = 1'b0;
  logic                    start_clear = 1'b0;
  logic                    flag_clear = 1'b0;
  logic                    trig = 1'b0;
  logic                    enable = 1'b1;
  logic                    irq_en = 1'b0;
  logic                    sleep = 1'b0;
  logic                    cmp = 1'b0;
  logic                    woke = 1'b0;
  logic [3:0]              rc_div = 4'h0;
  logic [9:0]              vin = 10'h2C5;
  acs_pkg::acs_config_type cfg = 7'h0E;
  logic                    ss, flag, wake, tmr, pwr, sh;
  logic [4:0]              chan = 5'h1F;
  logic [7:0]              hi, lo;
  logic [9:0]              trial;
  acs_pkg::acs_ref_type    refs;
  logic [4:0]              route;
  int                      fails = 0;
  int                      samples_checked = 0;
  int                      n;
  acs_sequencer acs_sequencer_i
  (
    .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .cfg(cfg), .channel_select(chan),
    .converter_enable(enable), .start_set(start_set), .start_clear(start_clear),
    .flag_clear(flag_clear), .conv_irq_enable(irq_en), .sleep_req(sleep),
    .compare_trigger(trig), .rc_tick(rc_div[3]), .comparator_out(cmp),
    .start_status(ss), .conv_complete_flag(flag), .wake_event(wake), .timer_reset(tmr),
    .result_high_byte(hi), .result_low_byte(lo), .trial_code(trial), .sample_hold(sh),
    .converter_powered(pwr), .ref_sel(refs), .channel_route(route)
  );
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cmp <= (vin >= trial);
    rc_div <= ss ? rc_div + 4'h1 : rc_div;
    woke <= woke | wake;
  end
  // =====================================
  // Helpers
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic kick(input logic [2:0] sel, input logic just);
    @(posedge clk_sys);
    cfg.conv_clock_select <= sel;
    cfg.result_justify <= just;
    @(posedge clk_sys);
    start_set <= 1'b1;
    @(posedge clk_sys);
    start_set <= 1'b0;
    #1;
  endtask
  task automatic wait_done();
    n = 0;
    while (ss === 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // =====================================
  // Scenarios
  task automatic t_clocks();
    logic [2:0] sel [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    for (int i = 0; i < 6; i++)
    begin
      kick(sel[i], i[0]);
      wait_done();
      check("cycles", 10'(23 * (1 << i)), 10'(n));
      @(posedge clk_sys);
      flag_clear <= 1'b1;
      #1;
      check("flag", 1'b1, flag);
      if (i >= 4)
      begin
        check("high", i[0] ? {6'h00, vin[9:8]} : vin[9:2], hi);
        check("low", i[0] ? vin[7:0] : {vin[1:0], 6'h00}, lo);
      end
      @(posedge clk_sys);
      flag_clear <= 1'b0;
      #1;
      check("cleared", 1'b0, flag);
    end
  endtask
  task automatic t_misc();
    vin <= 10'h3F0;
    chan <= 5'h0D;
    kick(3'h6, 1'b1);
    repeat (256) @(posedge clk_sys);
    start_clear <= 1'b1;
    #1;
    check("hold", 1'b0, sh);
    @(posedge clk_sys);
    start_clear <= 1'b0;
    enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check("partial", 10'h3FF, {hi[1:0], lo});
    check("route", 5'h0D, route);
    kick(3'h6, 1'b1);
    check("refused", 1'b0, ss);
    @(posedge clk_sys);
    enable <= 1'b1;
    @(posedge clk_sys);
    trig <= 1'b1;
    @(posedge clk_sys);
    trig <= 1'b0;
    #1;
    check("trigger", 2'b11, {ss, tmr | acs_sequencer_i.timer_reset});
    @(posedge clk_sys);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("sleep abort", 2'b00, {ss, pwr});
    sleep <= 1'b0;
    irq_en <= 1'b1;
    kick(3'h3, 1'b0);
    sleep <= 1'b1;
    wait_done();
    @(posedge clk_sys);
    #1;
    check("wake", 2'b11, {woke, flag});
    kick(3'h6, 1'b0);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("reset", 4'h0, {ss, flag, pwr, wake});
  endtask
  initial
  begin
    #(100 * 50000);
    fails++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("idle", 10'h0, {ss, flag, hi});
    check("hold", 1'b1, sh);
    check("refs", 4'b0101, refs);
    check("route", 5'h1F, route);
    t_clocks();
    t_misc();
    summarize();
  end
endmodule
bind acs_sequencer acs_sequencer_assertions acs_sequencer_assertions_i
(
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cfg(cfg),
  .converter_enable(converter_enable), .start_set(start_set), .start_clear(start_clear),
  .flag_clear(flag_clear), .conv_irq_enable(conv_irq_enable), .sleep_req(sleep_req),
  .compare_trigger(compare_trigger), .start_status(start_status),
  .conv_complete_flag(conv_complete_flag), .wake_event(wake_event),
  .timer_reset(timer_reset), .result_high_byte(result_high_byte),
  .result_low_byte(result_low_byte)
);
`default_nettype wire

// file: logic/acs_pkg.sv
// Constants and carrier types for the conversion sequencer.
// Assumes a single 10 MHz system clock and an external analog front end.
package acs_pkg;
  localparam int          RES_BITS      = 10;
  localparam logic [2:0]  CS_DIV2       = 3'h0;
  localparam logic [2:0]  CS_DIV8       = 3'h1;
  localparam logic [2:0]  CS_DIV32      = 3'h2;
  localparam logic [2:0]  CS_DIV4       = 3'h4;
  localparam logic [2:0]  CS_DIV16      = 3'h5;
  localparam logic [2:0]  CS_DIV64      = 3'h6;
  localparam logic [1:0]  PREF_SUPPLY   = 2'h0;
  localparam logic [1:0]  PREF_PIN      = 2'h2;
  localparam logic [1:0]  PREF_FIXED    = 2'h3;
  localparam logic [9:0]  RESULT_RST    = 10'h000;
  localparam logic [5:0]  RC_DIV_HALF   = 6'h08;
  localparam logic [3:0]  HALF_PERIODS  = 4'h2;

  typedef struct packed {
    logic       result_justify;
    logic [2:0] conv_clock_select;
    logic       neg_ref_select;
    logic [1:0] pos_ref_select;
  } acs_config_type;

  typedef struct packed {
    logic       pos_ref_supply;
    logic       pos_ref_pin;
    logic       pos_ref_fixed;
    logic       neg_ref_pin;
  } acs_ref_type;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SETTLE, ST_CONVERT} acs_state_type;
endpackage

// file: logic/acs_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes comparator and rc tick inputs arrive from other domains.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  input  var  acs_pkg::acs_config_type cfg,
  input  wire logic [4:0]             channel_select,
  input  wire logic                   converter_enable,
  input  wire logic                   start_set,
  input  wire logic                   start_clear,
  input  wire logic                   flag_clear,
  input  wire logic                   conv_irq_enable,
  input  wire logic                   sleep_req,
  input  wire logic                   compare_trigger,
  input  wire logic                   rc_tick,
  input  wire logic                   comparator_out,
  output logic                        start_status,
  output logic                        conv_complete_flag,
  output logic                        wake_event,
  output logic                        timer_reset,
  output logic [7:0]                  result_high_byte,
  output logic [7:0]                  result_low_byte,
  output logic [9:0]                  trial_code,
  output logic                        sample_hold,
  output logic                        converter_powered,
  output var  acs_pkg::acs_ref_type    ref_sel,
  output logic [4:0]                  channel_route
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] cmp_s_r;
  logic [1:0] rc_s_r;
  logic       rc_old_r;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      cmp_s_r  <= 2'h0;
      rc_s_r   <= 2'h0;
      rc_old_r <= 1'h0;
    end
    else if (clk_en)
    begin
      cmp_s_r  <= {cmp_s_r[0], comparator_out};
      rc_s_r   <= {rc_s_r[0], rc_tick};
      rc_old_r <= rc_s_r[1];
    end

  // ==========================================================
  // Half bit-period tick
  logic [5:0] div_r;
  logic [5:0] half_lim;
  logic       use_rc;
  logic       half_tick;
  assign use_rc = (cfg.conv_clock_select[1:0] == 2'h3);
  always_comb
  begin
    unique case (cfg.conv_clock_select)
      acs_pkg::CS_DIV2:  half_lim = 6'h00;
      acs_pkg::CS_DIV4:  half_lim = 6'h01;
      acs_pkg::CS_DIV8:  half_lim = 6'h03;
      acs_pkg::CS_DIV16: half_lim = 6'h07;
      acs_pkg::CS_DIV32: half_lim = 6'h0F;
      acs_pkg::CS_DIV64: half_lim = 6'h1F;
      default:           half_lim = acs_pkg::RC_DIV_HALF;
    endcase
  end
  // Divider counts system clocks, so it follows frequency changes
  assign half_tick = use_rc ? (rc_s_r[1] & ~rc_old_r) : (div_r >= half_lim);

  // ==========================================================
  // Sequencer
  acs_pkg::acs_state_type state_r;
  logic [3:0] bit_r;
  logic [3:0] wait_r;
  logic       phase_r;
  logic [9:0] sar_r;
  logic       last_r;
  logic       off_r;
  logic       go_r;
  logic       flag_r;
  logic       wake_r;
  logic       trst_r;
  logic [9:0] res_r;
  logic       running;
  logic       done_now;
  logic       abort_sw;
  logic       abort_sleep;
  logic       go_set;
  logic [9:0] fill;
  logic [9:0] done_code;
  assign running     = (state_r != acs_pkg::ST_IDLE);

  // Divider held at zero while idle, so every conversion not timed by the rc tick starts in phase
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      div_r <= 6'h00;
    else if (clk_en)
      div_r <= (half_tick | ~running) ? 6'h00 : div_r + 6'h01;
  assign go_set      = (start_set | compare_trigger) & converter_enable;
  assign abort_sw    = running & start_clear;
  assign abort_sleep = running & sleep_req & ~use_rc;
  assign done_now    = (state_r == acs_pkg::ST_CONVERT) & half_tick & phase_r
                       & (bit_r == 4'h0);
  // Unresolved bits copy the last decided bit
  assign fill        = {10{last_r}} & ~((10'h3FF << (bit_r + 4'h1)) & 10'h3FF);
  assign done_code   = {sar_r[9:1], cmp_s_r[1]};

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      state_r <= acs_pkg::ST_IDLE;
      bit_r   <= 4'h9;
      wait_r  <= 4'h0;
      phase_r <= 1'h0;
      sar_r   <= 10'h200;
      last_r  <= 1'h0;
      go_r    <= 1'h0;
      flag_r  <= 1'h0;
      off_r   <= 1'h0;
      wake_r  <= 1'h0;
      trst_r  <= 1'h0;
      res_r   <= acs_pkg::RESULT_RST;
    end
    else if (clk_en)
    begin
      wake_r <= 1'h0;
      trst_r <= compare_trigger & converter_enable;
      if (!sleep_req | !converter_enable)
        off_r <= 1'h0;
      // Set wins over a same-cycle clear
      if (flag_clear)
        flag_r <= 1'h0;
      if (!converter_enable)
      begin
        state_r <= acs_pkg::ST_IDLE;
        go_r    <= 1'h0;
      end
      else if (abort_sw | abort_sleep)
      begin
        state_r <= acs_pkg::ST_IDLE;
        go_r    <= 1'h0;
        if (abort_sw)
          res_r <= (sar_r & ~fill & ~(10'h1 << bit_r)) | fill;
        else
          off_r <= 1'h1;
      end
      else if (done_now)
      begin
        state_r <= acs_pkg::ST_IDLE;
        go_r    <= 1'h0;
        flag_r  <= 1'h1;
        res_r   <= done_code;
        wake_r  <= sleep_req & conv_irq_enable;
        off_r   <= sleep_req & ~conv_irq_enable;
      end
      else
      begin
        unique case (state_r)
          acs_pkg::ST_IDLE:
            if (go_set & ~(off_r & sleep_req))
            begin
              go_r    <= 1'h1;
              bit_r   <= 4'h9;
              wait_r  <= 4'h0;
              phase_r <= 1'h0;
              sar_r   <= 10'h200;
              state_r <= use_rc ? acs_pkg::ST_DELAY : acs_pkg::ST_SETTLE;
            end
          acs_pkg::ST_DELAY:
            state_r <= acs_pkg::ST_SETTLE;
          acs_pkg::ST_SETTLE:
            if (half_tick)
            begin
              // Settle of three half periods
              wait_r <= wait_r + 4'h1;
              if (wait_r == acs_pkg::HALF_PERIODS)
                state_r <= acs_pkg::ST_CONVERT;
            end
          acs_pkg::ST_CONVERT:
            if (half_tick)
            begin
              phase_r <= ~phase_r;
              if (phase_r)
              begin
                // Decide current bit, trial next one
                sar_r[bit_r] <= cmp_s_r[1];
                last_r       <= cmp_s_r[1];
                sar_r[bit_r - 4'h1] <= 1'h1;
                bit_r        <= bit_r - 4'h1;
              end
            end
        endcase
      end
    end

  // ==========================================================
  // Outputs
  logic [15:0] res_fmt;
  logic [7:0]  hi_r;
  logic [7:0]  lo_r;
  logic        pwr_r;
  logic [9:0]  trial_r;
  logic        sh_r;
  acs_pkg::acs_ref_type ref_r;
  logic [4:0]  chan_r;
  acs_pkg::acs_ref_type ref_nxt;
  // Justification with zeroed unused bits
  assign res_fmt = cfg.result_justify ? {6'h00, res_r} : {res_r, 6'h00};
  assign ref_nxt.pos_ref_supply = (cfg.pos_ref_select == acs_pkg::PREF_SUPPLY);
  assign ref_nxt.pos_ref_pin    = (cfg.pos_ref_select == acs_pkg::PREF_PIN);
  assign ref_nxt.pos_ref_fixed  = (cfg.pos_ref_select == acs_pkg::PREF_FIXED);
  assign ref_nxt.neg_ref_pin    = cfg.neg_ref_select;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      hi_r    <= 8'h00;
      lo_r    <= 8'h00;
      pwr_r   <= 1'h0;
      trial_r <= 10'h000;
      sh_r    <= 1'h0;
      ref_r   <= '0;
      chan_r  <= 5'h00;
    end
    else if (clk_en)
    begin
      hi_r    <= res_fmt[15:8];
      lo_r    <= res_fmt[7:0];
      pwr_r   <= converter_enable & ~off_r;
      trial_r <= sar_r;
      sh_r    <= ~running;
      ref_r   <= ref_nxt;
      chan_r  <= channel_select;
    end

  assign start_status       = go_r;
  assign conv_complete_flag = flag_r;
  assign wake_event         = wake_r;
  assign timer_reset        = trst_r;
  assign result_high_byte   = hi_r;
  assign result_low_byte    = lo_r;
  assign trial_code         = trial_r;
  assign sample_hold        = sh_r;
  assign converter_powered  = pwr_r;
  assign ref_sel            = ref_r;
  assign channel_route      = chan_r;
endmodule
`default_nettype wire
